// ===== verilog/reset_boot_pkg.sv
// Purpose: Shared constants and types for the reset tree and boot selection block
// Assumes: 20 MHz system clock
// Notes:   Boot codes and frequencies are the documented hardware values
package reset_boot_pkg;

  // Clock figures
  localparam int unsigned CLK_HZ              = 20_000_000;
  localparam int unsigned REF_CLK_HZ          = 25_000_000;

  // Boot select codes
  localparam logic [3:0] CODE_QUAD_FLASH      = 4'h0;
  localparam logic [3:0] CODE_UART            = 4'h1;
  localparam logic [3:0] CODE_SINGLE_FLASH    = 4'h2;
  localparam logic [3:0] CODE_OCTAL_FLASH     = 4'h3;
  localparam logic [3:0] CODE_XSPI            = 4'hC;
  localparam logic [3:0] CODE_USB_DFU         = 4'hE;
  localparam logic [3:0] CODE_DEV             = 4'hB;

  // Flash read commands
  localparam logic [7:0] CMD_QUAD_READ        = 8'h6B;
  localparam logic [7:0] CMD_SINGLE_READ      = 8'h0B;
  localparam logic [7:0] CMD_OCTAL_READ       = 8'h8B;
  localparam logic [7:0] CMD_NONE             = 8'h00;

  // Interface clock rates in MHz and link rates
  localparam logic [7:0] FLASH_MHZ_50         = 8'h32;
  localparam logic [7:0] FLASH_MHZ_33         = 8'h21;
  localparam logic [7:0] FLASH_MHZ_25         = 8'h19;
  localparam logic [7:0] FLASH_MHZ_NONE       = 8'h00;
  localparam int unsigned UART_BAUD           = 115200;
  localparam int unsigned USB_HS_MBPS         = 480;

  // Reset values
  localparam logic [3:0] BOOT_CODE_RST        = 4'h0;

  // Boot modes
  typedef enum logic [2:0] {
    BOOT_QUAD_FLASH   = 3'b000,
    BOOT_UART         = 3'b001,
    BOOT_SINGLE_FLASH = 3'b010,
    BOOT_OCTAL_FLASH  = 3'b011,
    BOOT_XSPI         = 3'b100,
    BOOT_USB_DFU      = 3'b101,
    BOOT_DEV          = 3'b110,
    BOOT_UNSUPPORTED  = 3'b111
  } boot_mode_e;

  // Loader state
  typedef enum logic [1:0] {
    LD_HOLD  = 2'b00,
    LD_LOAD  = 2'b01,
    LD_UART  = 2'b10,
    LD_DONE  = 2'b11
  } loader_state_e;

  // Decoded boot configuration
  typedef struct packed {
    boot_mode_e mode;
    logic [7:0] read_cmd;
    logic [7:0] flash_mhz;
    logic       fallback_uart;
    logic       sfdp_probe;
    logic       octal_ddr;
    logic       run_loader;
  } boot_cfg_s;

  // Reset tree outputs
  typedef struct packed {
    logic power_on_reset_n;
    logic flash_reset_n;
    logic boot_buffer_oe_n;
    logic connector_por_n;
  } por_fanout_s;

endpackage : reset_boot_pkg

// ===== verilog/pin_sync.sv
// Purpose: Three-stage synchroniser for one asynchronous pin
// Assumes: Reset already synchronised to clk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter logic INIT = 1'b1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pin in, filtered level out
  input  wire logic pin,
  output logic      level
);

  logic s1_reg, s2_reg, s3_reg, level_reg;
  logic level_next;

  // Accept a change once the last two stages agree
  always_comb begin
    level_next = level_reg;
    if (s2_reg == s3_reg) begin
      level_next = s3_reg;
    end
  end

  // Register the chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg    <= INIT;
      s2_reg    <= INIT;
      s3_reg    <= INIT;
      level_reg <= INIT;
    end else begin
      s1_reg    <= pin;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

endmodule : pin_sync

// ===== verilog/reset_tree_and_boot_select.sv
// Purpose: Board reset combining and boot mode selection for the main domain
// Assumes: All board inputs are asynchronous; all but load_done and load_failed pass three-stage synchronisers
// Notes:   Outputs are registered; pin-driven outputs follow their cause five or more cycles late, loader outputs follow load_done and load_failed one cycle late
//
// Overview of operation
// RULE1 - Reset is AND of three active-low sources
// RULE2 - One net feeds core, flash, buffer, connector
// RULE3 - Power-on reset resets the main domain
// RULE4 - Warm reset gives non-power-on main reset
// RULE5 - Warm reset low while its button held
// RULE6 - Warm net shared, also resets I/O expander
// RULE7 - Interrupt line low while button held
// RULE8 - Core gets 25 MHz reference clock; code drives clk/2, 10 MHz at the 20 MHz clock
// RULE9 - Code 0000 quad flash, 50 MHz, 0x6B
// RULE10 - Code 0001 UART boot, 115200, XMODEM
// RULE11 - Code 0010 single flash, 50 MHz, 0x0B
// RULE12 - Code 0011 octal flash, 33 MHz, 0x8B
// RULE13 - Code 1100 xSPI, 25 MHz, SFDP, 8D
// RULE14 - Flash must offer SFDP revision D
// RULE15 - Code 1110 USB DFU high speed, UART fallback
// RULE16 - Code 1011 development boot, no loader
// RULE17 - Flash load failure falls back to UART
// RULE18 - Other codes mean unsupported boot mode
// RULE19 - Code latched at reset release, held
`timescale 1ns/1ps
module reset_tree_and_boot_select (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rstn,
  // Reset sources, active low
  input  wire logic                      pmic_reset_out_n,
  input  wire logic                      regulator_power_good_n,
  input  wire logic                      power_on_button,
  input  wire logic                      warm_reset_button,
  input  wire logic                      warm_reset_out_n,
  input  wire logic                      user_interrupt_button,
  // Boot select switch, position 4 down to 1
  input  wire logic                      boot_sel_bit3,
  input  wire logic                      boot_sel_bit2,
  input  wire logic                      boot_sel_bit1,
  input  wire logic                      boot_sel_bit0,
  // Loader progress from the boot ROM
  input  wire logic                      load_done,
  input  wire logic                      load_failed,
  // Reset tree outputs
  output reset_boot_pkg::por_fanout_s    por_fanout,
  output logic                           main_domain_reset_n,
  output logic                           warm_reset_n_a,
  output logic                           button_board_reset_n,
  output logic                           io_expander_reset_n,
  output logic                           main_warm_reset_n,
  output logic                           user_interrupt_n,
  // Reference clock request
  output logic                           crystal_clock_in,
  // Boot selection
  output logic [3:0]                     boot_code,
  output reset_boot_pkg::boot_cfg_s      boot_cfg,
  output logic                           secondary_loader,
  output logic                           development_boot,
  output logic                           using_uart_fallback,
  output reset_boot_pkg::loader_state_e  loader_state
);

  // Reset release through two flip-flops
  logic rst_a_reg, rst_b_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_a_reg <= 1'b0;
      rst_b_reg <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_b_reg <= rst_a_reg;
    end
  end
  logic rst_n;
  assign rst_n = rst_b_reg;

  // Synchronised copies of every board pin except load_done and load_failed
  localparam int NPIN = 10;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_lvl;
  assign pin_raw = {boot_sel_bit3, boot_sel_bit2, boot_sel_bit1, boot_sel_bit0,
                    pmic_reset_out_n, regulator_power_good_n, power_on_button,
                    warm_reset_button, warm_reset_out_n, user_interrupt_button};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      pin_sync #(
        .INIT (gi < 6 ? 1'b1 : 1'b0)
      ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (pin_raw[gi]),
        .level (pin_lvl[gi])
      );
    end
  endgenerate

  logic [3:0] sel_sync;
  logic       pmic_s, pgood_s, por_btn_s, warm_btn_s, warm_out_s, int_btn_s;
  assign sel_sync   = pin_lvl[9:6];
  assign pmic_s     = pin_lvl[5];
  assign pgood_s    = pin_lvl[4];
  assign por_btn_s  = pin_lvl[3];
  assign warm_btn_s = pin_lvl[2];
  assign warm_out_s = pin_lvl[1];
  assign int_btn_s  = pin_lvl[0];

  // Reset tree next values
  logic por_reg, por_next;
  logic warm_reg, warm_next;
  logic int_reg, int_next;
  logic clk_div_reg, clk_div_next;
  always_comb begin
    por_next     = pmic_s & pgood_s & por_btn_s;   // RULE1
    warm_next    = warm_btn_s & warm_out_s;        // RULE5 RULE6
    int_next     = int_btn_s;                      // RULE7
    clk_div_next = ~clk_div_reg;                   // RULE8
  end

  // Reset tree registers; reset holds all resets asserted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      por_reg     <= 1'b0;
      warm_reg    <= 1'b0;
      int_reg     <= 1'b1;
      clk_div_reg <= 1'b0;
    end else begin
      por_reg     <= por_next;
      warm_reg    <= warm_next;
      int_reg     <= int_next;
      clk_div_reg <= clk_div_next;
    end
  end

  // Boot code capture and decode
  logic                       por_prev_reg, por_prev_next;
  logic [3:0]                 code_reg, code_next;
  reset_boot_pkg::boot_cfg_s  cfg_reg, cfg_next;
  reset_boot_pkg::boot_cfg_s  cfg_dec;

  // Decode a code into its boot configuration
  always_comb begin
    cfg_dec               = '0;
    cfg_dec.mode          = reset_boot_pkg::BOOT_UNSUPPORTED;  // RULE18
    cfg_dec.read_cmd      = reset_boot_pkg::CMD_NONE;
    cfg_dec.flash_mhz     = reset_boot_pkg::FLASH_MHZ_NONE;
    case (code_next)
      reset_boot_pkg::CODE_QUAD_FLASH: begin                     // RULE9
        cfg_dec.mode          = reset_boot_pkg::BOOT_QUAD_FLASH;
        cfg_dec.read_cmd      = reset_boot_pkg::CMD_QUAD_READ;
        cfg_dec.flash_mhz     = reset_boot_pkg::FLASH_MHZ_50;
        cfg_dec.fallback_uart = 1'b1;                            // RULE17
        cfg_dec.run_loader    = 1'b1;
      end
      reset_boot_pkg::CODE_UART: begin                           // RULE10
        cfg_dec.mode          = reset_boot_pkg::BOOT_UART;
        cfg_dec.run_loader    = 1'b1;
      end
      reset_boot_pkg::CODE_SINGLE_FLASH: begin                   // RULE11
        cfg_dec.mode          = reset_boot_pkg::BOOT_SINGLE_FLASH;
        cfg_dec.read_cmd      = reset_boot_pkg::CMD_SINGLE_READ;
        cfg_dec.flash_mhz     = reset_boot_pkg::FLASH_MHZ_50;
        cfg_dec.fallback_uart = 1'b1;                            // RULE17
        cfg_dec.run_loader    = 1'b1;
      end
      reset_boot_pkg::CODE_OCTAL_FLASH: begin                    // RULE12
        cfg_dec.mode          = reset_boot_pkg::BOOT_OCTAL_FLASH;
        cfg_dec.read_cmd      = reset_boot_pkg::CMD_OCTAL_READ;
        cfg_dec.flash_mhz     = reset_boot_pkg::FLASH_MHZ_33;
        cfg_dec.fallback_uart = 1'b1;                            // RULE17
        cfg_dec.run_loader    = 1'b1;
      end
      reset_boot_pkg::CODE_XSPI: begin                           // RULE13
        cfg_dec.mode          = reset_boot_pkg::BOOT_XSPI;
        cfg_dec.flash_mhz     = reset_boot_pkg::FLASH_MHZ_25;
        cfg_dec.sfdp_probe    = 1'b1;                            // RULE14
        cfg_dec.octal_ddr     = 1'b1;
        cfg_dec.fallback_uart = 1'b1;                            // RULE17
        cfg_dec.run_loader    = 1'b1;
      end
      reset_boot_pkg::CODE_USB_DFU: begin                        // RULE15
        cfg_dec.mode          = reset_boot_pkg::BOOT_USB_DFU;
        cfg_dec.fallback_uart = 1'b1;
        cfg_dec.run_loader    = 1'b1;
      end
      reset_boot_pkg::CODE_DEV: begin                            // RULE16
        cfg_dec.mode          = reset_boot_pkg::BOOT_DEV;
      end
      default: begin
        cfg_dec.mode          = reset_boot_pkg::BOOT_UNSUPPORTED;  // RULE18
      end
    endcase
  end

  // Latch the code on the rising edge of the power-on reset
  always_comb begin
    por_prev_next = por_reg;
    code_next     = code_reg;
    cfg_next      = cfg_reg;
    if (!por_prev_reg && por_reg) begin
      code_next = sel_sync;                                      // RULE19
    end
    if (!por_prev_reg && por_reg) begin
      cfg_next = cfg_dec;                                        // RULE19
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      por_prev_reg <= 1'b0;
      code_reg     <= reset_boot_pkg::BOOT_CODE_RST;
      cfg_reg      <= '0;
    end else begin
      por_prev_reg <= por_prev_next;
      code_reg     <= code_next;
      cfg_reg      <= cfg_next;
    end
  end

  // Loader sequence after power-on reset release
  reset_boot_pkg::loader_state_e ld_reg, ld_next;
  logic                          fb_reg, fb_next;
  always_comb begin
    ld_next = ld_reg;
    fb_next = fb_reg;
    case (ld_reg)
      reset_boot_pkg::LD_HOLD: begin
        if (por_prev_reg && por_reg && warm_reg) begin           // RULE3 RULE4
          if (!cfg_reg.run_loader) begin
            ld_next = reset_boot_pkg::LD_DONE;                   // RULE16
          end else begin
            ld_next = reset_boot_pkg::LD_LOAD;
          end
        end
      end
      reset_boot_pkg::LD_LOAD: begin
        if (load_failed && cfg_reg.fallback_uart) begin
          ld_next = reset_boot_pkg::LD_UART;                     // RULE17 RULE15
          fb_next = 1'b1;
        end else if (load_done) begin
          ld_next = reset_boot_pkg::LD_DONE;
        end
      end
      reset_boot_pkg::LD_UART: begin
        if (load_done) begin
          ld_next = reset_boot_pkg::LD_DONE;
        end
      end
      reset_boot_pkg::LD_DONE: begin
        ld_next = reset_boot_pkg::LD_DONE;
      end
      default: begin
        ld_next = reset_boot_pkg::LD_HOLD;
      end
    endcase
    if (!por_reg || !warm_reg) begin                             // RULE3 RULE4
      ld_next = reset_boot_pkg::LD_HOLD;
      fb_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_reg <= reset_boot_pkg::LD_HOLD;
      fb_reg <= 1'b0;
    end else begin
      ld_reg <= ld_next;
      fb_reg <= fb_next;
    end
  end

  // Output wiring from flip-flops
  assign por_fanout.power_on_reset_n = por_reg;                  // RULE2
  assign por_fanout.flash_reset_n    = por_reg;                  // RULE2
  assign por_fanout.boot_buffer_oe_n = por_reg;                  // RULE2
  assign por_fanout.connector_por_n  = por_reg;                  // RULE2
  assign main_domain_reset_n         = por_reg;                  // RULE3
  assign warm_reset_n_a              = warm_reg;                 // RULE5
  assign button_board_reset_n        = warm_reg;                 // RULE6
  assign io_expander_reset_n         = warm_reg;                 // RULE6
  assign main_warm_reset_n           = warm_reg;                 // RULE4
  assign user_interrupt_n            = int_reg;
  assign crystal_clock_in            = clk_div_reg;
  assign boot_code                   = code_reg;
  assign boot_cfg                    = cfg_reg;
  assign secondary_loader            = cfg_reg.run_loader;
  assign development_boot            = (cfg_reg.mode == reset_boot_pkg::BOOT_DEV);
  assign using_uart_fallback         = fb_reg;
  assign loader_state                = ld_reg;

endmodule : reset_tree_and_boot_select

// ===== bench/reset_boot_chk.sv
// Purpose: Port-level checks of the reset tree and boot selection
// Assumes: Outputs settle within eight cycles of a steady cause
// Notes:   Bound to the top module at the foot of this file
`timescale 1ns/1ps
module reset_boot_chk (
  // Clock and reset
  input wire logic                           clk,
  input wire logic                           rstn,
  // Board sources
  input wire logic                           pmic_reset_out_n,
  input wire logic                           regulator_power_good_n,
  input wire logic                           power_on_button,
  input wire logic                           warm_reset_button,
  input wire logic                           user_interrupt_button,
  input wire logic                           load_failed,
  // Reset tree outputs
  input wire reset_boot_pkg::por_fanout_s    por_fanout,
  input wire logic                           main_domain_reset_n,
  input wire logic                           warm_reset_n_a,
  input wire logic                           button_board_reset_n,
  input wire logic                           io_expander_reset_n,
  input wire logic                           main_warm_reset_n,
  input wire logic                           user_interrupt_n,
  input wire logic                           crystal_clock_in,
  // Boot selection outputs
  input wire logic [3:0]                     boot_code,
  input wire reset_boot_pkg::boot_cfg_s      boot_cfg,
  input wire logic                           secondary_loader,
  input wire logic                           development_boot,
  input wire logic                           using_uart_fallback,
  input wire reset_boot_pkg::loader_state_e  loader_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // All three power-on sources released
  wire src_ok = pmic_reset_out_n & regulator_power_good_n & power_on_button;

  // Reset tree relations
  chk_por_high: assert property (src_ok [*8] |-> por_fanout.power_on_reset_n)
    else $error("power-on reset stuck low");
  chk_por_low: assert property ((!src_ok) [*8] |-> !main_domain_reset_n)
    else $error("power-on reset missed a source");
  chk_fanout_net: assert property (por_fanout == {4{main_domain_reset_n}})
    else $error("power-on fanout split");
  chk_warm_low: assert property ((!warm_reset_button) [*8] |-> !main_warm_reset_n)
    else $error("warm reset missed button");
  chk_warm_net: assert property ({warm_reset_n_a, button_board_reset_n, io_expander_reset_n} == {3{main_warm_reset_n}})
    else $error("warm reset net split");
  chk_int_low: assert property ((!user_interrupt_button) [*8] |-> !user_interrupt_n)
    else $error("interrupt missed button");
  chk_int_high: assert property (user_interrupt_button [*8] |-> user_interrupt_n)
    else $error("interrupt stuck low");
  chk_ref_toggle: assert property (main_domain_reset_n && $past(main_domain_reset_n) |-> crystal_clock_in != $past(crystal_clock_in))
    else $error("reference clock stalled");

  // Boot selection relations
  chk_code_held: assert property (main_domain_reset_n [*3] |-> $stable(boot_code))
    else $error("boot code moved while running");
  chk_dev_noload: assert property (development_boot |-> !secondary_loader && boot_cfg.mode == reset_boot_pkg::BOOT_DEV)
    else $error("development boot runs loader");
  chk_unsup_idle: assert property (boot_cfg.mode == reset_boot_pkg::BOOT_UNSUPPORTED |-> !secondary_loader)
    else $error("unsupported mode runs loader");
  chk_fallback_uart: assert property (loader_state == reset_boot_pkg::LD_LOAD && load_failed && boot_cfg.fallback_uart && main_domain_reset_n && main_warm_reset_n |=> !main_domain_reset_n || !main_warm_reset_n || (loader_state == reset_boot_pkg::LD_UART && using_uart_fallback))
    else $error("no fallback after failed load");
endmodule : reset_boot_chk

bind reset_tree_and_boot_select reset_boot_chk u_chk (
  .clk(clk), .rstn(rstn), .pmic_reset_out_n(pmic_reset_out_n), .regulator_power_good_n(regulator_power_good_n),
  .power_on_button(power_on_button), .warm_reset_button(warm_reset_button),
  .user_interrupt_button(user_interrupt_button), .load_failed(load_failed), .por_fanout(por_fanout),
  .main_domain_reset_n(main_domain_reset_n), .warm_reset_n_a(warm_reset_n_a),
  .button_board_reset_n(button_board_reset_n), .io_expander_reset_n(io_expander_reset_n),
  .main_warm_reset_n(main_warm_reset_n), .user_interrupt_n(user_interrupt_n), .crystal_clock_in(crystal_clock_in),
  .boot_code(boot_code), .boot_cfg(boot_cfg), .secondary_loader(secondary_loader),
  .development_boot(development_boot), .using_uart_fallback(using_uart_fallback), .loader_state(loader_state));

// ===== bench/board_model.sv
// Purpose: Board side: supply monitors, buttons, boot switch, boot ROM reports
// Assumes: Tasks are called just after a rising clock edge
// Notes:   Buttons read low while pressed
`timescale 1ns/1ps
module board_model (
  // Power-on sources
  output logic       pmic_reset_out_n,
  output logic       regulator_power_good_n,
  output logic       power_on_button,
  // Buttons and core warm output
  output logic       warm_reset_button,
  output logic       warm_reset_out_n,
  output logic       user_interrupt_button,
  // Switch, position 4 first
  output logic [3:0] sw_code,
  // Boot ROM reports
  output logic [1:0] load_rep
);
  // Idle board at time zero
  initial begin
    {pmic_reset_out_n, regulator_power_good_n, power_on_button} = 3'h7;
    {warm_reset_button, warm_reset_out_n, user_interrupt_button} = 3'h7;
    sw_code = 4'h0;
    load_rep = 2'h0;
  end
  // PMIC, regulator and power-on button
  task automatic set_por(input logic [2:0] v);
    {pmic_reset_out_n, regulator_power_good_n, power_on_button} = v;
  endtask : set_por
  // Warm button, core warm output, interrupt button
  task automatic set_btn(input logic [2:0] v);
    {warm_reset_button, warm_reset_out_n, user_interrupt_button} = v;
  endtask : set_btn
  // Switch code
  task automatic set_code(input logic [3:0] c);
    sw_code = c;
  endtask : set_code
  // Done and failed, from a flash offering revision D SFDP only
  task automatic set_load(input logic [1:0] v);
    load_rep = v;
  endtask : set_load
endmodule : board_model

// ===== bench/reset_tree_and_boot_select_tb.sv
// Purpose: Self-checking bench for the reset tree and boot selection
// Assumes: Inputs change 2 ns after a rising edge
// Notes:   Random por mixes and switch codes from a fixed seed
`timescale 1ns/1ps
module reset_tree_and_boot_select_tb;
  logic                          clk = 1'h0;
  logic                          rstn = 1'h0;
  int                            n_mismatch = 0;
  int                            check_count = 0;
  integer                        seed = 32'hF5C9;
  wire logic                     pmic_reset_out_n, regulator_power_good_n, power_on_button;
  wire logic                     warm_reset_button, warm_reset_out_n, user_interrupt_button;
  wire logic [3:0]               sw_code;
  wire logic [1:0]               load_rep;
  reset_boot_pkg::por_fanout_s   por_fanout;
  logic                          main_domain_reset_n, warm_reset_n_a, button_board_reset_n, io_expander_reset_n;
  logic                          main_warm_reset_n, user_interrupt_n, crystal_clock_in;
  logic                          secondary_loader, development_boot, using_uart_fallback;
  logic [3:0]                    boot_code;
  reset_boot_pkg::boot_cfg_s     boot_cfg;
  reset_boot_pkg::loader_state_e loader_state;

  // Clock, 50 ns period
  always #25 clk = ~clk;

  board_model board (.pmic_reset_out_n(pmic_reset_out_n), .regulator_power_good_n(regulator_power_good_n),
    .power_on_button(power_on_button), .warm_reset_button(warm_reset_button), .warm_reset_out_n(warm_reset_out_n),
    .user_interrupt_button(user_interrupt_button), .sw_code(sw_code), .load_rep(load_rep));

  reset_tree_and_boot_select dut (.clk(clk), .rstn(rstn), .pmic_reset_out_n(pmic_reset_out_n),
    .regulator_power_good_n(regulator_power_good_n), .power_on_button(power_on_button),
    .warm_reset_button(warm_reset_button), .warm_reset_out_n(warm_reset_out_n),
    .user_interrupt_button(user_interrupt_button), .boot_sel_bit3(sw_code[3]), .boot_sel_bit2(sw_code[2]),
    .boot_sel_bit1(sw_code[1]), .boot_sel_bit0(sw_code[0]), .load_done(load_rep[1]), .load_failed(load_rep[0]),
    .por_fanout(por_fanout), .main_domain_reset_n(main_domain_reset_n), .warm_reset_n_a(warm_reset_n_a),
    .button_board_reset_n(button_board_reset_n), .io_expander_reset_n(io_expander_reset_n),
    .main_warm_reset_n(main_warm_reset_n), .user_interrupt_n(user_interrupt_n), .crystal_clock_in(crystal_clock_in),
    .boot_code(boot_code), .boot_cfg(boot_cfg), .secondary_loader(secondary_loader),
    .development_boot(development_boot), .using_uart_fallback(using_uart_fallback), .loader_state(loader_state));

  // Wait n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  // Report a mismatch
  task automatic miss(input string what);
    n_mismatch++;
    $display("CHECK FAILED at %0t: %s", $time, what);
  endtask : miss
  // Compare tasks, one per kind of result
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) miss(what);
  endtask : cmp_bit
  task automatic cmp_vec(input logic [3:0] got, input logic [3:0] exp, input string what);
    check_count++;
    if (got !== exp) miss(what);
  endtask : cmp_vec
  task automatic cmp_cfg(input reset_boot_pkg::boot_cfg_s got, input reset_boot_pkg::boot_cfg_s exp);
    check_count++;
    if (got !== exp) miss("boot config");
  endtask : cmp_cfg
  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Expected decode, fields in struct order
  function automatic reset_boot_pkg::boot_cfg_s exp_cfg(input logic [3:0] c);
    case (c)
      4'h0: return '{reset_boot_pkg::BOOT_QUAD_FLASH, 8'h6B, 8'h32, 1'h1, 1'h0, 1'h0, 1'h1};
      4'h1: return '{reset_boot_pkg::BOOT_UART, 8'h00, 8'h00, 1'h0, 1'h0, 1'h0, 1'h1};
      4'h2: return '{reset_boot_pkg::BOOT_SINGLE_FLASH, 8'h0B, 8'h32, 1'h1, 1'h0, 1'h0, 1'h1};
      4'h3: return '{reset_boot_pkg::BOOT_OCTAL_FLASH, 8'h8B, 8'h21, 1'h1, 1'h0, 1'h0, 1'h1};
      4'hC: return '{reset_boot_pkg::BOOT_XSPI, 8'h00, 8'h19, 1'h1, 1'h1, 1'h1, 1'h1};
      4'hE: return '{reset_boot_pkg::BOOT_USB_DFU, 8'h00, 8'h00, 1'h1, 1'h0, 1'h0, 1'h1};
      4'hB: return '{reset_boot_pkg::BOOT_DEV, 8'h00, 8'h00, 1'h0, 1'h0, 1'h0, 1'h0};
      default: return '{reset_boot_pkg::BOOT_UNSUPPORTED, 8'h00, 8'h00, 1'h0, 1'h0, 1'h0, 1'h0};
    endcase
  endfunction : exp_cfg

  // Hang guard
  initial begin
    #2000000;
    miss("run limit reached");
    test_done();
  end

  // Main sequence
  initial begin
    logic [2:0]                v;
    logic [3:0]                c;
    reset_boot_pkg::boot_cfg_s e;
    int                        cnt;
    logic                      prev;
    repeat (4) @(posedge clk);
    #2 rstn = 1'h1;
    tick(10);
    // Every source mix, then random mixes
    for (int i = 0; i < 24; i++) begin
      v = (i < 8) ? i[2:0] : 3'($random(seed));
      board.set_por(v);
      tick(10);
      cmp_bit(main_domain_reset_n, &v, "por tree");
      cmp_vec(por_fanout, {4{&v}}, "por fanout");
    end
    $display("test por tree done");
    // Every switch code, then random codes; later switch moves ignored
    for (int i = 0; i < 24; i++) begin
      c = (i < 16) ? i[3:0] : 4'($random(seed));
      e = exp_cfg(c);
      board.set_code(c);
      board.set_por(3'h6);
      tick(10);
      board.set_por(3'h7);
      tick(10);
      board.set_code(~c);
      tick(4);
      cmp_vec(boot_code, c, "code latch");
      cmp_cfg(boot_cfg, e);
      cmp_bit(development_boot, c == 4'hB, "development boot");
      cmp_bit(secondary_loader, e.run_loader, "loader run");
      cmp_vec(4'(loader_state), e.run_loader ? 4'h1 : 4'h3, "loader start");
      board.set_load(2'h1);
      tick(1);
      board.set_load(2'h0);
      tick(2);
      cmp_vec(4'(loader_state), !e.run_loader ? 4'h3 : e.fallback_uart ? 4'h2 : 4'h1, "after fail");
      cmp_bit(using_uart_fallback, e.run_loader & e.fallback_uart, "fallback flag");
      board.set_load(2'h2);
      tick(1);
      board.set_load(2'h0);
      tick(2);
      cmp_vec(4'(loader_state), 4'h3, "after done");
    end
    $display("test boot select done");
    // Warm button, core warm output, interrupt button in turn
    for (int k = 2; k >= 0; k--) begin
      v = 3'($random(seed)) & ~(3'h1 << k);
      board.set_btn(v);
      tick(10);
      cmp_bit(warm_reset_n_a, v[2] & v[1], "warm net");
      cmp_bit(io_expander_reset_n, v[2] & v[1], "expander reset");
      cmp_bit(main_domain_reset_n, 1'h1, "warm is not por");
      cmp_vec(4'(loader_state), (v[2] & v[1]) ? e.run_loader ? 4'h1 : 4'h3 : 4'h0, "warm holds loader");
      cmp_bit(user_interrupt_n, v[0], "interrupt line");
      board.set_btn(3'h7);
      tick(10);
      cmp_bit(warm_reset_n_a & user_interrupt_n, 1'h1, "release");
    end
    $display("test buttons done");
    // Reference clock toggles every cycle
    cnt = 0;
    repeat (20) begin
      prev = crystal_clock_in;
      tick(1);
      if (crystal_clock_in !== prev) cnt++;
    end
    cmp_bit(cnt == 20, 1'h1, "reference clock");
    $display("test clock done");
    test_done();
  end
endmodule : reset_tree_and_boot_select_tb
